// ===== design/qpt_crc.v
// qpt_crc.v: byte-wide frame check sequence accumulator.
// assumes bytes arrive least significant bit first on the wire.
`timescale 1ns/100ps
`include "qpt_map.vh"
module qpt_crc (
    input  wire        clk_i,    // core clock
    input  wire        resetn_i, // sync reset, low active
    input  wire        ce_i,     // clock enable
    input  wire        clr_i,    // restart for next frame
    input  wire        vld_i,    // byte valid
    input  wire [7:0]  data_i,   // byte
    output wire [31:0] crc_o     // running remainder
);

    reg [31:0] crc_r;

    function [31:0] crc_byte;
        input [31:0] c;
        input [7:0]  d;
        integer      k;
        reg   [31:0] t;
        begin
            t = c ^ {24'h000000, d};
            for (k = 0; k < 8; k = k + 1) begin
                t = t[0] ? ((t >> 1) ^ `QPT_CRC_POLY) : (t >> 1);
            end
            crc_byte = t;
        end
    endfunction

    assign crc_o = crc_r;

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            crc_r <= `QPT_CRC_INIT;
        end else if (ce_i) begin
            if (clr_i) begin
                crc_r <= `QPT_CRC_INIT;
            end else if (vld_i) begin
                crc_r <= crc_byte(crc_r, data_i);
            end
        end
    end

endmodule // qpt_crc

// ===== design/qpt_engine.v
// qpt_engine.v: per-port priority classifier, queue scheduler and egress
// tag editor with fcs regeneration.
// assumes the fabric hands frames without fcs, one byte per beat.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "qpt_map.vh"
module qpt_engine #(
    parameter FIFO_D  = 8,
    parameter FIFO_AW = 3
) (
    input  wire        clk_i,        // core clock
    input  wire        resetn_i,     // sync reset, low
    input  wire        ce_i,         // clock enable
    input  wire [7:0]  addr_i,       // reg address
    input  wire [7:0]  wdata_i,      // write data
    input  wire        wr_i,         // write strobe
    input  wire        rd_i,         // read strobe
    output reg  [7:0]  rdata_o,      // read data
    input  wire        cl_valid_i,   // descriptor valid
    input  wire        cl_tagged_i,  // vlan tagged
    input  wire [2:0]  cl_pcp_i,     // tag pcp
    input  wire        cl_ip_i,      // ip frame
    input  wire [7:0]  cl_tos_i,     // tos byte
    output reg         cl_valid_o,   // result valid
    output reg  [1:0]  cl_prio_o,    // level
    output reg  [1:0]  cl_queue_o,   // queue
    output reg  [2:0]  cl_pcp_o,     // pcp out
    input  wire        sch_req_i,    // grant request
    input  wire [3:0]  sch_pend_i,   // queues pending
    output reg         sch_valid_o,  // grant valid
    output reg         sch_hit_o,    // queue granted
    output reg  [1:0]  sch_queue_o,  // granted queue
    input  wire        eg_valid_i,   // byte valid
    output wire        eg_ready_o,   // byte ready
    input  wire [7:0]  eg_data_i,    // byte
    input  wire        eg_last_i,    // last byte
    input  wire        eg_tagged_i,  // already tagged
    input  wire [2:0]  eg_src_i,     // ingress port
    input  wire [15:0] eg_src_tci_i, // ingress tag
    output reg         tx_valid_o,   // mac valid
    input  wire        tx_ready_i,   // mac ready
    output reg  [7:0]  tx_data_o,    // mac byte
    output reg         tx_last_o     // last fcs byte
);

    // ****************
    // registers
    // ****************
    localparam FW = 27;
    reg [7:0]  ctl0_r, ctl2_r, ctl3_r, ctl4_r, ctl8_r, ctl9_r, sched_r;
    reg [7:0]  wgt_r [0:3];
    reg [7:0]  map_lo_r, map_hi_r, map2q_r;
    reg [7:0]  tos_r [0:15];
    reg [7:0]  frames_r;
    integer    i, j, k;

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            ctl0_r   <= `QPT_R_ZERO;
            ctl2_r   <= `QPT_R_ZERO;
            ctl3_r   <= `QPT_R_ZERO;
            ctl4_r   <= `QPT_R_ZERO;
            ctl8_r   <= `QPT_R_ZERO;
            ctl9_r   <= `QPT_R_ZERO;
            sched_r  <= `QPT_R_ZERO;
            wgt_r[0] <= `QPT_R_W0;
            wgt_r[1] <= `QPT_R_W1;
            wgt_r[2] <= `QPT_R_W2;
            wgt_r[3] <= `QPT_R_W3;
            map_lo_r <= `QPT_R_MAP_LO;
            map_hi_r <= `QPT_R_MAP_HI;
            map2q_r  <= `QPT_R_MAP2Q;
            for (i = 0; i < 16; i = i + 1) begin
                tos_r[i] <= `QPT_R_ZERO;
            end
        end else if (ce_i && wr_i) begin
            case (addr_i)
                `QPT_A_CTL0:   ctl0_r   <= wdata_i;
                `QPT_A_CTL2:   ctl2_r   <= wdata_i;
                `QPT_A_CTL3:   ctl3_r   <= wdata_i;
                `QPT_A_CTL4:   ctl4_r   <= wdata_i;
                `QPT_A_CTL8:   ctl8_r   <= wdata_i;
                `QPT_A_CTL9:   ctl9_r   <= wdata_i;
                `QPT_A_SCHED:  sched_r  <= wdata_i;
                `QPT_A_MAP_LO: map_lo_r <= wdata_i;
                `QPT_A_MAP_HI: map_hi_r <= wdata_i;
                `QPT_A_MAP2Q:  map2q_r  <= wdata_i;
                default: begin
                    // weights keep only bits 6:0
                    if (addr_i >= `QPT_A_CTL10 && addr_i <= `QPT_A_CTL13) begin
                        wgt_r[addr_i[1:0] - 2'h2] <= {1'b0, wdata_i[6:0]};
                    end
                    if (addr_i >= `QPT_A_TOS_FIRST && addr_i <= `QPT_A_TOS_LAST) begin
                        tos_r[addr_i[3:0]] <= wdata_i;
                    end
                end
            endcase
        end
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_o <= `QPT_R_ZERO;
        end else if (ce_i) begin
            rdata_o <= `QPT_R_ZERO;
            if (rd_i) begin
                case (addr_i)
                    `QPT_A_CTL0:   rdata_o <= ctl0_r;
                    `QPT_A_CTL2:   rdata_o <= ctl2_r;
                    `QPT_A_CTL3:   rdata_o <= ctl3_r;
                    `QPT_A_CTL4:   rdata_o <= ctl4_r;
                    `QPT_A_CTL8:   rdata_o <= ctl8_r;
                    `QPT_A_CTL9:   rdata_o <= ctl9_r;
                    `QPT_A_STAT:   rdata_o <= frames_r;
                    `QPT_A_SCHED:  rdata_o <= sched_r;
                    `QPT_A_MAP_LO: rdata_o <= map_lo_r;
                    `QPT_A_MAP_HI: rdata_o <= map_hi_r;
                    `QPT_A_MAP2Q:  rdata_o <= map2q_r;
                    default: begin
                        if (addr_i >= `QPT_A_CTL10 && addr_i <= `QPT_A_CTL13) begin
                            rdata_o <= wgt_r[addr_i[1:0] - 2'h2];
                        end
                        if (addr_i >= `QPT_A_TOS_FIRST && addr_i <= `QPT_A_TOS_LAST) begin
                            rdata_o <= tos_r[addr_i[3:0]];
                        end
                    end
                endcase
            end
        end
    end

    // ****************
    // ingress classification
    // ****************
    // mode 3 is taken as single queue
    wire [1:0] qmode = {ctl9_r[`QPT_B_SPLIT_HI], ctl0_r[`QPT_B_SPLIT_LO]};

    function [1:0] max2;
        input [1:0] a;
        input [1:0] b;
        begin
            max2 = (a > b) ? a : b;
        end
    endfunction

    reg [2:0]  pcp_eff;
    reg [1:0]  lvl;
    reg [1:0]  q_sel;
    reg [15:0] map16;
    reg [7:0]  tos_b;

    always @* begin
        pcp_eff = cl_pcp_i;
        if (ctl2_r[`QPT_B_CEIL_EN] && cl_tagged_i && cl_pcp_i > ctl3_r[7:5]) begin
            pcp_eff = ctl3_r[7:5];
        end
        map16 = {map_hi_r, map_lo_r};
        tos_b = tos_r[cl_tos_i[7:4]];
        lvl   = ctl0_r[`QPT_B_PPRIO_LO+1:`QPT_B_PPRIO_LO];
        if (ctl0_r[`QPT_B_DOT1P_EN] && cl_tagged_i) begin
            lvl = max2(lvl, map16[{pcp_eff, 1'b0} +: 2]);
        end
        if (ctl0_r[`QPT_B_DSCP_EN] && cl_ip_i) begin
            lvl = max2(lvl, tos_b[{cl_tos_i[3:2], 1'b0} +: 2]);
        end
        case (qmode)
            2'h1:    q_sel = (lvl >= map2q_r[7:6]) ? 2'h1 : 2'h0;
            2'h2:    q_sel = lvl;
            default: q_sel = 2'h0;
        endcase
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            cl_valid_o <= 1'b0;
            cl_prio_o  <= 2'h0;
            cl_queue_o <= 2'h0;
            cl_pcp_o   <= 3'h0;
        end else if (ce_i) begin
            cl_valid_o <= cl_valid_i;
            if (cl_valid_i) begin
                cl_prio_o  <= lvl;
                cl_queue_o <= q_sel;
                cl_pcp_o   <= pcp_eff;
            end
        end
    end

    // ****************
    // queue scheduler
    // ****************
    reg [6:0] cr_r [0:3];
    reg [3:0] pend;
    reg [3:0] elig;
    reg       reload;

    function [1:0] top_q; // highest set bit wins
        input [3:0] m;
        begin
            top_q = m[3] ? 2'h3 : m[2] ? 2'h2 : m[1] ? 2'h1 : 2'h0;
        end
    endfunction

    always @* begin
        case (qmode)
            2'h1:    pend = sch_pend_i & 4'h3;
            2'h2:    pend = sch_pend_i;
            default: pend = sch_pend_i & 4'h1;
        endcase
        for (j = 0; j < 4; j = j + 1) begin
            elig[j] = pend[j] & (cr_r[j] != 7'h00);
        end
        reload = sched_r[`QPT_B_WFQ_EN] && (qmode == 2'h2) && (pend != 4'h0) && (elig == 4'h0);
        if (reload) begin
            for (j = 0; j < 4; j = j + 1) begin
                elig[j] = pend[j] & (wgt_r[j][6:0] != 7'h00);
            end
        end
        // a zero-weight queue is still served once all others are dry
        if (!sched_r[`QPT_B_WFQ_EN] || qmode != 2'h2 || elig == 4'h0) begin
            elig = pend;
        end
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            sch_valid_o <= 1'b0;
            sch_hit_o   <= 1'b0;
            sch_queue_o <= 2'h0;
            for (k = 0; k < 4; k = k + 1) begin
                cr_r[k] <= 7'h00;
            end
        end else if (ce_i) begin
            sch_valid_o <= sch_req_i;
            if (sch_req_i) begin
                sch_hit_o   <= (pend != 4'h0);
                sch_queue_o <= top_q(elig);
                for (k = 0; k < 4; k = k + 1) begin
                    if (reload) begin
                        cr_r[k] <= wgt_r[k][6:0];
                    end
                end
                if (pend != 4'h0) begin
                    if (reload) begin
                        cr_r[top_q(elig)] <= wgt_r[top_q(elig)][6:0] - 7'h01;
                    end else if (cr_r[top_q(elig)] != 7'h00) begin
                        cr_r[top_q(elig)] <= cr_r[top_q(elig)] - 7'h01;
                    end
                end
            end
        end
    end

    // ****************
    // egress buffer and tag editor
    // ****************
    localparam ST_BODY = 2'h0;
    localparam ST_INS  = 2'h1;
    localparam ST_FCS  = 2'h2;

    wire [FW-1:0] f_in = {eg_src_tci_i, ctl8_r[eg_src_i], eg_tagged_i, eg_last_i, eg_data_i};
    wire [FW-1:0] f_out;
    wire          f_valid;
    reg           f_pop;
    wire [31:0]   crc_q;
    reg           crc_v, crc_c;

    qpt_fifo #(
        .W  (FW),
        .D  (FIFO_D),
        .AW (FIFO_AW)
    ) u_fifo (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .ce_i        (ce_i),
        .in_valid_i  (eg_valid_i),
        .in_ready_o  (eg_ready_o),
        .in_data_i   (f_in),
        .out_valid_o (f_valid),
        .out_ready_i (f_pop),
        .out_data_o  (f_out)
    );

    reg [1:0] st_r, st_nxt;
    reg [4:0] cnt_r, cnt_nxt;
    reg [1:0] idx_r, idx_nxt;
    reg       done_r, done_nxt;
    reg [7:0] od_nxt;
    reg       ov_nxt, ol_nxt;
    wire      out_free = ~tx_valid_o | tx_ready_i;
    wire      f_last = f_out[8];
    wire      f_tag  = f_out[9];
    wire      f_ins  = f_out[10];
    wire [15:0] f_tci = f_out[26:11];
    wire      do_ins = ctl0_r[`QPT_B_TAG_INS] & f_ins & ~f_tag & ~done_r;
    wire      do_del = ctl0_r[`QPT_B_TAG_DEL] & f_tag & (cnt_r >= `QPT_TAG_OFFSET)
                       & (cnt_r < `QPT_TAG_END);

    always @* begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        idx_nxt  = idx_r;
        done_nxt = done_r;
        od_nxt   = tx_data_o;
        ov_nxt   = tx_valid_o & ~tx_ready_i;
        ol_nxt   = tx_last_o;
        f_pop    = 1'b0;
        crc_v    = 1'b0;
        crc_c    = 1'b0;
        if (out_free) begin
            case (st_r)
                ST_BODY: begin
                    if (f_valid && cnt_r == `QPT_TAG_OFFSET && do_ins) begin
                        st_nxt  = ST_INS;
                        od_nxt  = `QPT_VPID_HI;
                        ov_nxt  = 1'b1;
                        ol_nxt  = 1'b0;
                        crc_v   = 1'b1;
                        idx_nxt = 2'h1;
                    end else if (f_valid) begin
                        f_pop = 1'b1;
                        if (cnt_r != `QPT_TAG_END) begin
                            cnt_nxt = cnt_r + 5'h01;
                        end
                        if (!do_del) begin
                            od_nxt = f_out[7:0];
                            ov_nxt = 1'b1;
                            ol_nxt = 1'b0;
                            crc_v  = 1'b1;
                        end
                        if (f_last) begin
                            st_nxt   = ST_FCS;
                            idx_nxt  = 2'h0;
                            cnt_nxt  = 5'h00;
                            done_nxt = 1'b0;
                        end
                    end
                end
                ST_INS: begin
                    // head word stays unpopped so its tag stays visible
                    case (idx_r)
                        2'h1:    od_nxt = `QPT_VPID_LO;
                        2'h2:    od_nxt = f_tci[15:8];
                        default: od_nxt = f_tci[7:0];
                    endcase
                    ov_nxt  = 1'b1;
                    ol_nxt  = 1'b0;
                    crc_v   = 1'b1;
                    idx_nxt = idx_r + 2'h1;
                    if (idx_r == 2'h3) begin
                        st_nxt   = ST_BODY;
                        done_nxt = 1'b1;
                    end
                end
                ST_FCS: begin
                    od_nxt  = ~crc_q[{idx_r, 3'h0} +: 8];
                    ov_nxt  = 1'b1;
                    ol_nxt  = (idx_r == 2'h3);
                    idx_nxt = idx_r + 2'h1;
                    if (idx_r == 2'h3) begin
                        st_nxt = ST_BODY;
                        crc_c  = 1'b1;
                    end
                end
                default: st_nxt = ST_BODY;
            endcase
        end
    end

    qpt_crc u_crc (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .clr_i    (crc_c),
        .vld_i    (crc_v),
        .data_i   (od_nxt),
        .crc_o    (crc_q)
    );

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            st_r       <= ST_BODY;
            cnt_r      <= 5'h00;
            idx_r      <= 2'h0;
            done_r     <= 1'b0;
            tx_valid_o <= 1'b0;
            tx_data_o  <= 8'h00;
            tx_last_o  <= 1'b0;
            frames_r   <= 8'h00;
        end else if (ce_i) begin
            st_r       <= st_nxt;
            cnt_r      <= cnt_nxt;
            idx_r      <= idx_nxt;
            done_r     <= done_nxt;
            tx_valid_o <= ov_nxt;
            tx_data_o  <= od_nxt;
            tx_last_o  <= ol_nxt;
            if (crc_c) begin
                frames_r <= frames_r + 8'h01;
            end
        end
    end

endmodule // qpt_engine

// ===== design/qpt_fifo.v
// qpt_fifo.v: synchronous word fifo with valid/ready on both sides.
// assumes one clock; the drain side may stall freely.
`timescale 1ns/100ps
module qpt_fifo #(
    parameter W  = 27,
    parameter D  = 8,
    parameter AW = 3
) (
    input  wire         clk_i,       // core clock
    input  wire         resetn_i,    // sync reset, low active
    input  wire         ce_i,        // clock enable
    input  wire         in_valid_i,  // write side valid
    output wire         in_ready_o,  // write side ready
    input  wire [W-1:0] in_data_i,   // write word
    output wire         out_valid_o, // read side valid
    input  wire         out_ready_i, // read side ready
    output wire [W-1:0] out_data_o   // read word
);

    reg [W-1:0]  mem_r [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0]   cnt_r;
    wire         push;
    wire         pop;

    assign in_ready_o  = (cnt_r != D[AW:0]);
    assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
    assign out_data_o  = mem_r[rp_r];
    assign push        = ce_i & in_valid_i & in_ready_o;
    assign pop         = ce_i & out_valid_o & out_ready_i;

    always @(posedge clk_i) begin
        if (push) begin
            mem_r[wp_r] <= in_data_i;
        end
    end

    // depth need not be a power of two, so pointers wrap explicitly
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
            end
            if (pop) begin
                rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end

endmodule // qpt_fifo

// ===== dv/qpt_engine_sva.sv
// checker: port assertions of the tag engine.
// assumes ce_i high; shadows the config writes itself.
`timescale 1ns/100ps
module qpt_engine_sva (
    input wire       clk_i,       // clk
    input wire       resetn_i,    // rst
    input wire       ce_i,        // en
    input wire [7:0] addr_i,      // addr
    input wire [7:0] wdata_i,     // wdata
    input wire       wr_i,        // write
    input wire       cl_valid_i,  // desc
    input wire       cl_valid_o,  // result
    input wire [1:0] cl_prio_o,   // level
    input wire [1:0] cl_queue_o,  // queue
    input wire       sch_req_i,   // req
    input wire [3:0] sch_pend_i,  // pend
    input wire       sch_valid_o, // answer
    input wire       sch_hit_o,   // hit
    input wire [1:0] sch_queue_o, // grant
    input wire       tx_valid_o,  // valid
    input wire       tx_ready_i,  // ready
    input wire [7:0] tx_data_o    // byte
);
    reg  [7:0] c0_r, c9_r, q2_r, sd_r;
    wire [1:0] md = {c9_r[1], c0_r[0]};
    wire [1:0] pl = c0_r[4:3];
    wire       hi2 = cl_prio_o >= q2_r[7:6];
    wire       req = ce_i && sch_req_i;
    wire       strict4 = !sd_r[0] && md == 2'b10;
    wire       q3 = sch_hit_o && sch_queue_o == 2'd3;
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            {c0_r, c9_r, sd_r} <= 24'h000000;
            q2_r <= 8'h80;
        end else if (ce_i && wr_i) begin
            case (addr_i)
                8'h10: c0_r <= wdata_i;
                8'h19: c9_r <= wdata_i;
                8'h82: q2_r <= wdata_i;
                8'h1f: sd_r <= wdata_i;
                default: ;
            endcase
        end
    end
    default clocking dck @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    a_cl_answer: assert property (ce_i |=> cl_valid_o == $past(cl_valid_i))
        else $error("classifier valid wrong");
    a_one_queue: assert property (cl_valid_o && md[0] == md[1] |-> cl_queue_o == 2'd0)
        else $error("unsplit port used a queue above 0");
    a_four_queue: assert property (cl_valid_o && md == 2'b10 |-> cl_queue_o == cl_prio_o)
        else $error("four queue map wrong");
    a_two_queue: assert property (cl_valid_o && md == 2'b01 |-> cl_queue_o == {1'b0, hi2})
        else $error("two queue map wrong");
    a_port_floor: assert property (ce_i && cl_valid_i |=> cl_prio_o >= $past(pl))
        else $error("level below port level");
    a_strict_top: assert property (req && strict4 && sch_pend_i[3] |=> q3)
        else $error("queue 3 not served first");
    a_sch_empty: assert property (req && sch_pend_i == 4'h0 |=> sch_valid_o && !sch_hit_o)
        else $error("grant with nothing pending");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("tx byte dropped under stall");
    cover property (sch_valid_o && sch_hit_o && sch_queue_o == 2'd0);
    cover property (cl_valid_o && md == 2'b01 && cl_queue_o == 2'd1);
    cover property (tx_valid_o && !tx_ready_i);
endmodule // qpt_engine_sva
bind qpt_engine qpt_engine_sva u_sva (.*);

// ===== dv/qpt_engine_tb_top.sv
// bench: registers, classifier, scheduler, egress.
// assumes ce_i high.
`timescale 1ns/100ps
module qpt_engine_tb_top;
    logic clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, cl_valid_i = 0, cl_tagged_i = 0;
    logic cl_ip_i = 0, sch_req_i = 0, eg_valid_i = 0, eg_last_i = 0, eg_tagged_i = 0;
    logic [7:0] addr_i = 0, wdata_i = 0, cl_tos_i = 0, eg_data_i = 0, m [0:255] = '{default: 0};
    logic [2:0] cl_pcp_i = 0, eg_src_i = 0;
    logic [3:0] sch_pend_i = 0;
    logic [15:0] eg_src_tci_i = 0;
    wire ce_i = 1'b1;
    wire [7:0] rdata_o, tx_data_o;
    wire [2:0] cl_pcp_o;
    wire [1:0] cl_prio_o, cl_queue_o, sch_queue_o;
    wire cl_valid_o, sch_valid_o, sch_hit_o, eg_ready_o, tx_valid_o, tx_ready_i, tx_last_o;
    int n_fail = 0, n_checks = 0;
    int unsigned sd = 7464;
    qpt_engine dut (.*);
    qpt_mac_model mac (.clk_i(clk_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
        .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));
    initial forever #5 clk_i = ~clk_i;
    initial begin
        #400000;
        n_fail++;
        stop_test();
    end
    function logic [31:0] rnd();
        sd ^= sd << 13;
        sd ^= sd >> 17;
        sd ^= sd << 5;
        return sd;
    endfunction
    task chk(string s, logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", s, e, g);
        end
    endtask
    task wr(logic [7:0] a, d);
        @(posedge clk_i);
        {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
        m[a] = d & ((a > 8'h19 && a < 8'h1e) ? 8'h7f : 8'hff);
        @(posedge clk_i);
        wr_i <= 0;
    endtask
    task rdc(logic [7:0] a, e);
        @(posedge clk_i);
        {addr_i, rd_i} <= {a, 1'b1};
        @(posedge clk_i);
        rd_i <= 0;
        #1 chk("rdata", e, rdata_o);
    endtask
    function logic [6:0] ex(logic t, logic [2:0] p, logic i, logic [7:0] s);
        logic [2:0] c;
        logic [1:0] l, v, md;
        c = (m[8'h12][7] && t && p > m[8'h13][7:5]) ? m[8'h13][7:5] : p;
        l = m[8'h10][4:3];
        v = 2'({m[8'h81], m[8'h80]} >> (2 * c));
        if (m[8'h10][5] && t && v > l) l = v;
        v = 2'(m[8'h90 + s[7:4]] >> (2 * s[3:2]));
        if (m[8'h10][6] && i && v > l) l = v;
        md = {m[8'h19][1], m[8'h10][0]};
        v = (md == 2'b10) ? l : (md == 2'b01) ? {1'b0, l >= m[8'h82][7:6]} : 2'b00;
        return {l, v, c};
    endfunction
    function logic [2:0] top(logic [3:0] p, logic [1:0] md);
        logic [3:0] k;
        k = p & (md == 2'b10 ? 4'hf : md == 2'b01 ? 4'h3 : 4'h1);
        top = 3'b000;
        for (int i = 0; i < 4; i++) if (k[i]) top = {1'b1, 2'(i)};
    endfunction
    task sch(logic [3:0] p, logic [2:0] e);
        @(posedge clk_i);
        {sch_req_i, sch_pend_i} <= {1'b1, p};
        @(posedge clk_i);
        sch_req_i <= 0;
        #1 chk("grant", {1'b1, e}, {sch_valid_o, sch_hit_o, sch_hit_o ? sch_queue_o : 2'b00});
    endtask
    task automatic frm(int n, logic t, logic [2:0] s, logic [15:0] c);
        logic [7:0] b[$], e[$];
        logic [31:0] x;
        int f;
        f = mac.nfr;
        x = 32'hffffffff;
        for (int i = 0; i < n; i++) begin
            b.push_back(8'(rnd()));
            if (i == 12 && !t && m[8'h10][2] && m[8'h18][s]) e = {e, 8'h81, 8'h00, c[15:8], c[7:0]};
            if (!(t && m[8'h10][1] && i > 11 && i < 16)) e.push_back(b[i]);
        end
        foreach (e[j]) begin
            x ^= e[j];
            repeat (8) x = x[0] ? (x >> 1) ^ 32'hedb88320 : x >> 1;
        end
        x = ~x;
        e = {e, x[7:0], x[15:8], x[23:16], x[31:24]};
        foreach (b[i]) begin
            {eg_valid_i, eg_data_i, eg_last_i, eg_tagged_i, eg_src_i, eg_src_tci_i} <=
                {1'b1, b[i], i == n - 1, t, s, c};
            do @(negedge clk_i); while (!eg_ready_o);
            @(posedge clk_i);
        end
        eg_valid_i <= 0;
        for (int k = 0; k < 600 && mac.nfr == f; k++) @(posedge clk_i);
        chk("size", e.size(), mac.q.size());
        foreach (e[j]) chk("byte", e[j], mac.q.pop_front());
    endtask
    task stop_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        logic [31:0] r, q;
        logic [6:0] e;
        {m[8'h1a], m[8'h1b], m[8'h1c], m[8'h1d], m[8'h80], m[8'h81], m[8'h82]} = 56'h0804020150fa80;
        repeat (10) @(posedge clk_i);
        resetn_i <= 1;
        for (logic [7:0] a = 8'h10; a < 8'h20; a++) rdc(a, m[a]);
        for (logic [7:0] a = 8'h7f; a < 8'h91; a++) rdc(a, m[a]);
        wr(8'h1a, 8'hff);
        rdc(8'h1a, 8'h7f);
        wr(8'h1a, 8'h08);
        repeat (60) begin
            r = rnd();
            q = rnd();
            wr(8'h10, {1'b0, r[6:0]});
            wr(8'h12, r[15:8]);
            wr(8'h13, r[23:16]);
            wr(8'h19, {6'h00, r[24], 1'b0});
            wr(8'h80 + r[26:25], q[31:24]);
            wr(8'h90 + r[30:27], q[23:16]);
            @(posedge clk_i);
            {cl_valid_i, cl_tagged_i, cl_pcp_i, cl_ip_i, cl_tos_i} <= {1'b1, q[12:0]};
            e = ex(q[12], q[11:9], q[8], q[7:0]);
            @(posedge clk_i);
            cl_valid_i <= 0;
            #1 chk("level", e[6:5], cl_prio_o);
            chk("queue", e[4:3], cl_queue_o);
            chk("pcp", e[2:0], cl_pcp_o);
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h10, {7'h00, k[0]});
            wr(8'h19, {6'h00, k[1], 1'b0});
            repeat (6) begin
                r = rnd();
                sch(r[3:0], top(r[3:0], k[1:0]));
            end
        end
        wr(8'h10, 8'h00);
        wr(8'h1f, 8'h01);
        for (int i = 0; i < 15; i++) sch(4'hf, {1'b1, i < 1 ? 2'd3 : i < 3 ? 2'd2 : i < 7 ? 2'd1 : 2'd0});
        wr(8'h1f, 8'h00);
        repeat (12) begin
            r = rnd();
            wr(8'h10, {5'h00, r[2:1], 1'b0});
            wr(8'h18, {3'h0, r[7:3]});
            frm(r[8] ? 16 + r[11:9] : 1 + r[13:9], r[8], 3'(r[16:14] % 5), r[31:16]);
        end
        rdc(8'h1e, 8'h0c);
        stop_test();
    end
endmodule // qpt_engine_tb_top

// ===== dv/qpt_mac_model.sv
// mac model: stores bytes, random stalls.
// assumes the core clock.
`timescale 1ns/100ps
module qpt_mac_model (
    input  wire       clk_i,      // clk
    input  wire       tx_valid_i, // valid
    input  wire [7:0] tx_data_i,  // byte
    input  wire       tx_last_i,  // last
    output reg        tx_ready_o  // ready
);
    logic [7:0]  q[$];
    int          nfr = 0;
    int unsigned s = 5;
    initial tx_ready_o = 1'b0;
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            q.push_back(tx_data_i);
            nfr += tx_last_i;
        end
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        tx_ready_o <= s[0] | s[1];
    end
endmodule // qpt_mac_model

// ===== include/qpt_map.vh
// qpt_map.vh: offsets, fields and reset values of the tag engine.
// assumes inclusion by bare name.
`ifndef QPT_MAP_VH
`define QPT_MAP_VH

// per-port controls
`define QPT_A_CTL0 8'h10
`define QPT_A_CTL2 8'h12
`define QPT_A_CTL3 8'h13
`define QPT_A_CTL4 8'h14
`define QPT_A_CTL8 8'h18
`define QPT_A_CTL9 8'h19
`define QPT_A_CTL10 8'h1a
`define QPT_A_CTL13 8'h1d
`define QPT_A_STAT 8'h1e
`define QPT_A_SCHED 8'h1f
// global maps
`define QPT_A_MAP_LO 8'h80
`define QPT_A_MAP_HI 8'h81
`define QPT_A_MAP2Q 8'h82
`define QPT_A_TOS_FIRST 8'h90
`define QPT_A_TOS_LAST 8'h9f

// control 0 fields
`define QPT_B_SPLIT_LO 0
`define QPT_B_TAG_DEL 1
`define QPT_B_TAG_INS 2
`define QPT_B_PPRIO_LO 3
`define QPT_B_DOT1P_EN 5
`define QPT_B_DSCP_EN 6
// other fields
`define QPT_B_SPLIT_HI 1
`define QPT_B_CEIL_EN 7
`define QPT_B_WFQ_EN 0

// reset values
`define QPT_R_ZERO 8'h00
`define QPT_R_W0 8'h08
`define QPT_R_W1 8'h04
`define QPT_R_W2 8'h02
`define QPT_R_W3 8'h01
`define QPT_R_MAP_LO 8'h50
`define QPT_R_MAP_HI 8'hfa
`define QPT_R_MAP2Q 8'h80

// frame layout
`define QPT_TAG_OFFSET 5'h0c
`define QPT_TAG_END 5'h10
`define QPT_VPID_HI 8'h81
`define QPT_VPID_LO 8'h00
`define QPT_CRC_INIT 32'hffffffff
`define QPT_CRC_POLY 32'hedb88320

`endif
